/* hw/aludec_top.sv */
`timescale 1ns/100ps
module aludec_top
  import aludec_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [7:0]            fetch_byte_i,
  input  wire logic                  fetch_valid_i,
  output logic                       fetch_ready_o,
  output logic                       busy_o,
  output logic                       issue_o,
  output aludec_pkg::aludec_op_e     op_o,
  output aludec_pkg::aludec_src_e    src_o,
  output logic                       dst_dir_o,
  output logic [2:0]                 reg_sel_o,
  output logic                       ptr_sel_o,
  output logic [7:0]                 operand1_o,
  output logic [7:0]                 operand2_o,
  output logic [1:0]                 len_o,
  output logic [2:0]                 mcyc_o,
  output logic                       illegal_o
);
  import aludec_pkg::*;

  typedef enum logic [1:0] {
    ST_OPC  = 2'h0,
    ST_OPR1 = 2'h1,
    ST_OPR2 = 2'h2,
    ST_EXEC = 2'h3
  } aludec_st_e;

  typedef struct packed {
    aludec_st_e  st;
    logic [7:0]  opcode;
    logic [7:0]  opr1;
    logic [7:0]  opr2;
    logic [3:0]  clk_left;
    logic        issue;
    logic        illegal;
  } aludec_state_s;

  aludec_state_s cur;
  aludec_state_s next_cur;

  aludec_op_e  dec_op;
  aludec_src_e dec_src;
  logic        dec_dst;
  logic [1:0]  dec_len;
  logic [2:0]  dec_mcyc;
  logic [2:0]  dec_reg;
  logic        dec_ptr;
  logic        dec_valid;

  aludec_table u_table (
    .opcode_i  (cur.opcode),
    .op_o      (dec_op),
    .src_o     (dec_src),
    .dst_dir_o (dec_dst),
    .len_o     (dec_len),
    .mcyc_o    (dec_mcyc),
    .reg_sel_o (dec_reg),
    .ptr_sel_o (dec_ptr),
    .valid_o   (dec_valid)
  );

  // System clocks for a machine cycle count, as a 4-bit value
  function automatic logic [3:0] clocks_of(input logic [2:0] m);
    clocks_of = 4'(int'(m) * CLK_PER_MCYC);
  endfunction : clocks_of

  logic take;
  assign take          = fetch_valid_i && fetch_ready_o;
  assign fetch_ready_o = (cur.st != ST_EXEC);

  always_comb begin
    next_cur       = cur;
    next_cur.issue = 1'b0;
    case (cur.st)
      ST_OPC: begin
        if (take) begin
          next_cur.opcode  = fetch_byte_i;
          next_cur.opr1    = 8'h00;
          next_cur.opr2    = 8'h00;
          next_cur.illegal = 1'b0;
          next_cur.st      = ST_OPR1;
        end
      end
      // Opcode is now registered; decode decides operand fetches
      ST_OPR1: begin
        if (!dec_valid) begin
          next_cur.illegal = 1'b1;
          next_cur.st      = ST_OPC;
        end else if (dec_len == LEN_ONE) begin
          next_cur.clk_left = clocks_of(dec_mcyc) - 4'h1;
          next_cur.issue    = 1'b1;
          next_cur.st       = ST_EXEC;
        end else if (take) begin
          next_cur.opr1 = fetch_byte_i;
          if (dec_len == LEN_THREE) begin
            next_cur.st = ST_OPR2;
          end else begin
            next_cur.clk_left = clocks_of(dec_mcyc) - 4'h1;
            next_cur.issue    = 1'b1;
            next_cur.st       = ST_EXEC;
          end
        end
      end
      ST_OPR2: begin
        if (take) begin
          next_cur.opr2     = fetch_byte_i;
          next_cur.clk_left = clocks_of(dec_mcyc) - 4'h1;
          next_cur.issue    = 1'b1;
          next_cur.st       = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Hold fetch off for the whole execution window
        if (cur.clk_left == 4'h0) begin
          next_cur.st = ST_OPC;
        end else begin
          next_cur.clk_left = cur.clk_left - 4'h1;
        end
      end
      default: next_cur.st = ST_OPC;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur <= '{st: ST_OPC, opcode: 8'h00, opr1: 8'h00, opr2: 8'h00, clk_left: 4'h0, issue: 1'b0, illegal: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Opcode in ST_OPR1 transitions cleanly; outputs valid while busy
  assign busy_o     = (cur.st != ST_OPC);
  assign issue_o    = cur.issue;
  assign op_o       = dec_op;
  assign src_o      = dec_src;
  assign dst_dir_o  = dec_dst;
  assign reg_sel_o  = dec_reg;
  assign ptr_sel_o  = dec_ptr;
  assign len_o      = dec_len;
  assign mcyc_o     = dec_mcyc;
  assign operand1_o = cur.opr1;
  assign operand2_o = cur.opr2;
  assign illegal_o  = cur.illegal;

  // Counts execution cycles already finished, so the last cycle sees one less than the span
  int exec_len;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      exec_len <= 0;
    end else if (cur.issue) begin
      exec_len <= 1;
    end else if (cur.st == ST_EXEC) begin
      exec_len <= exec_len + 1;
    end
  end

  chk_mcyc_legal: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    issue_o |-> (mcyc_o == MCYC_ONE || mcyc_o == MCYC_TWO || mcyc_o == MCYC_FOUR))
    else $error("execution time not 1, 2 or 4 machine cycles");
  chk_exec_span: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cur.st == ST_EXEC && next_cur.st == ST_OPC) |-> (exec_len + 1 == int'(mcyc_o) * CLK_PER_MCYC))
    else $error("execution span is not two clocks per machine cycle");
  chk_len_legal: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    issue_o |-> (len_o != 2'h0))
    else $error("instruction length out of range");
  chk_three_byte: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && len_o == LEN_THREE) |-> (dst_dir_o && mcyc_o == MCYC_TWO && $past(cur.st) == ST_OPR2))
    else $error("three-byte form mis-timed");
  chk_and_dir_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode == 8'h52) |-> (op_o == ALU_AND && len_o == LEN_TWO && mcyc_o == MCYC_ONE))
    else $error("AND direct, accumulator decoded wrong");
  chk_add_reg: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode[7:3] == 5'h05) |-> (op_o == ALU_ADD && src_o == SRC_REG && len_o == LEN_ONE))
    else $error("ADD register row decoded wrong");
  chk_subb_imm: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode == 8'h94) |-> (op_o == ALU_SUBB && src_o == SRC_IMM && len_o == LEN_TWO))
    else $error("SUBB immediate decoded wrong");
  chk_rotate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && src_o == SRC_ACC && !dst_dir_o) |-> (len_o == LEN_ONE ##1 (cur.st == ST_EXEC) ##1 !busy_o))
    else $error("rotate not one byte, one machine cycle");
  chk_reg_sel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    issue_o |-> (reg_sel_o == cur.opcode[2:0] && ptr_sel_o == cur.opcode[0]))
    else $error("register or pointer select mismatch");
  chk_span_one: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && mcyc_o == MCYC_ONE) |-> (busy_o [*2] ##1 !busy_o))
    else $error("one machine cycle is not two clocks busy");
  chk_span_two: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && mcyc_o == MCYC_TWO) |-> (busy_o [*4] ##1 !busy_o))
    else $error("two machine cycles are not four clocks busy");
  chk_or_dir_imm: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode == 8'h43) |-> (op_o == ALU_OR && len_o == LEN_THREE && mcyc_o == MCYC_TWO))
    else $error("OR direct, immediate decoded wrong");
  chk_xor_dir_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode == 8'h62) |-> (op_o == ALU_XOR && dst_dir_o && len_o == LEN_TWO && mcyc_o == MCYC_ONE))
    else $error("XOR direct, accumulator decoded wrong");
  chk_addc_dir: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (issue_o && cur.opcode == 8'h35) |-> (op_o == ALU_ADDC && src_o == SRC_DIR && len_o == LEN_TWO))
    else $error("ADDC direct decoded wrong");

  cov_one_byte:   cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) issue_o && len_o == LEN_ONE);
  cov_two_byte:   cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) issue_o && len_o == LEN_TWO);
  cov_three_byte: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) issue_o && len_o == LEN_THREE);
  cov_illegal:    cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) illegal_o);

endmodule : aludec_top

/* hw/aludec_pkg.sv */
package aludec_pkg;

  localparam int          SYS_CLK_MHZ     = 100;
  localparam int          CLK_PER_MCYC    = 2;
  localparam logic [1:0]  LEN_ONE         = 2'h1;
  localparam logic [1:0]  LEN_TWO         = 2'h2;
  localparam logic [1:0]  LEN_THREE       = 2'h3;
  localparam logic [2:0]  MCYC_ONE        = 3'h1;
  localparam logic [2:0]  MCYC_TWO        = 3'h2;
  localparam logic [2:0]  MCYC_FOUR       = 3'h4;
  localparam int          REG_SEL_LSB     = 0;
  localparam int          REG_SEL_W       = 3;
  localparam int          PTR_SEL_BIT     = 0;

  // Opcode high nibble of each operation family
  localparam logic [3:0]  OPH_ADD         = 4'h2;
  localparam logic [3:0]  OPH_ADDC        = 4'h3;
  localparam logic [3:0]  OPH_SUBB        = 4'h9;
  localparam logic [3:0]  OPH_ANL         = 4'h5;
  localparam logic [3:0]  OPH_ORL         = 4'h4;
  localparam logic [3:0]  OPH_XRL         = 4'h6;
  localparam logic [7:0]  OPC_RL          = 8'h23;
  localparam logic [7:0]  OPC_RLC         = 8'h33;
  localparam logic [7:0]  OPC_RR          = 8'h03;
  localparam logic [7:0]  OPC_RRC         = 8'h13;

  // Low-nibble address mode of the grouped rows
  localparam logic [3:0]  LO_DIR_A        = 4'h2;
  localparam logic [3:0]  LO_DIR_IMM      = 4'h3;
  localparam logic [3:0]  LO_IMM          = 4'h4;
  localparam logic [3:0]  LO_DIR          = 4'h5;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_ADD  = 4'h1,
    ALU_ADDC = 4'h2,
    ALU_SUBB = 4'h3,
    ALU_AND  = 4'h4,
    ALU_OR   = 4'h5,
    ALU_XOR  = 4'h6,
    ALU_RL   = 4'h7,
    ALU_RLC  = 4'h8,
    ALU_RR   = 4'h9,
    ALU_RRC  = 4'ha
  } aludec_op_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_REG  = 3'h1,
    SRC_DIR  = 3'h2,
    SRC_IND  = 3'h3,
    SRC_IMM  = 3'h4,
    SRC_ACC  = 3'h5
  } aludec_src_e;

endpackage : aludec_pkg

/* hw/aludec_table.sv */
`timescale 1ns/100ps
module aludec_table
  import aludec_pkg::*;
(
  input  wire logic [7:0]            opcode_i,
  output aludec_pkg::aludec_op_e     op_o,
  output aludec_pkg::aludec_src_e    src_o,
  output logic                       dst_dir_o,
  output logic [1:0]                 len_o,
  output logic [2:0]                 mcyc_o,
  output logic [2:0]                 reg_sel_o,
  output logic                       ptr_sel_o,
  output logic                       valid_o
);

  function automatic aludec_op_e fam(input logic [3:0] hi);
    case (hi)
      OPH_ADD:  fam = ALU_ADD;
      OPH_ADDC: fam = ALU_ADDC;
      OPH_SUBB: fam = ALU_SUBB;
      OPH_ANL:  fam = ALU_AND;
      OPH_ORL:  fam = ALU_OR;
      OPH_XRL:  fam = ALU_XOR;
      default:  fam = ALU_NONE;
    endcase
  endfunction : fam

  logic [3:0] hi;
  logic [3:0] lo;
  logic       logic_fam;
  assign hi        = opcode_i[7:4];
  assign lo        = opcode_i[3:0];
  assign logic_fam = (hi == OPH_ANL) || (hi == OPH_ORL) || (hi == OPH_XRL);

  assign reg_sel_o = opcode_i[REG_SEL_LSB +: REG_SEL_W];
  assign ptr_sel_o = opcode_i[PTR_SEL_BIT];

  always_comb begin
    op_o      = ALU_NONE;
    src_o     = SRC_NONE;
    dst_dir_o = 1'b0;
    len_o     = LEN_ONE;
    mcyc_o    = MCYC_ONE;
    valid_o   = 1'b0;
    if (opcode_i == OPC_RL || opcode_i == OPC_RLC || opcode_i == OPC_RR || opcode_i == OPC_RRC) begin
      valid_o = 1'b1;
      src_o   = SRC_ACC;
      case (opcode_i)
        OPC_RL:  op_o = ALU_RL;
        OPC_RLC: op_o = ALU_RLC;
        OPC_RR:  op_o = ALU_RR;
        default: op_o = ALU_RRC;
      endcase
    end else if (fam(hi) != ALU_NONE) begin
      op_o = fam(hi);
      if (lo[3]) begin
        valid_o = 1'b1;
        src_o   = SRC_REG;
      end else if (lo[3:1] == 3'h3) begin
        valid_o = 1'b1;
        src_o   = SRC_IND;
      end else if (lo == LO_DIR) begin
        valid_o = 1'b1;
        src_o   = SRC_DIR;
        len_o   = LEN_TWO;
      end else if (lo == LO_IMM) begin
        valid_o = 1'b1;
        src_o   = SRC_IMM;
        len_o   = LEN_TWO;
      end else if (logic_fam && lo == LO_DIR_A) begin
        valid_o   = 1'b1;
        src_o     = SRC_ACC;
        dst_dir_o = 1'b1;
        len_o     = LEN_TWO;
      end else if (logic_fam && lo == LO_DIR_IMM) begin
        valid_o   = 1'b1;
        src_o     = SRC_IMM;
        dst_dir_o = 1'b1;
        len_o     = LEN_THREE;
        mcyc_o    = MCYC_TWO;
      end else begin
        op_o = ALU_NONE;
      end
    end
  end

endmodule : aludec_table

/* dv/aludec_fetch_model.sv */
`timescale 1ns/100ps
module aludec_fetch_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ready_i,
  input  wire logic       stall_i,
  output logic [7:0]      byte_o,
  output logic            valid_o,
  output logic            done_o
);
  logic [7:0] bytes [3];
  int         idx  = 0;
  int         cnt  = 0;
  logic       hold = 1'b0;
  initial begin
    byte_o  = 8'h5a;
    valid_o = 1'b0;
  end
  assign done_o = (idx >= cnt);
  task automatic load(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    bytes[0] = b0;
    bytes[1] = b1;
    bytes[2] = b2;
    cnt = n;
    idx = 0;
  endtask : load
  // Idle bus shows inverted data each cycle so a stale byte can never look valid
  always @(posedge clk_i) begin
    if (valid_o && ready_i) idx++;
    #1;
    hold    = stall_i && !hold;
    valid_o = rst_n_i && (idx < cnt) && !hold;
    byte_o  = valid_o ? bytes[idx] : ~byte_o;
  end
endmodule : aludec_fetch_model

/* dv/tb.sv */
`timescale 1ns/100ps
module tb;
  import aludec_pkg::*;
  typedef struct {
    logic        ill;
    aludec_op_e  op;
    aludec_src_e src;
    logic        dst;
    logic [1:0]  len;
    logic [2:0]  mc;
    logic [7:0]  opc, o1, o2;
  } aludec_exp_s;
  logic        sys_clk, reset_n = 1'b0, stall = 1'b0;
  logic [7:0]  fetch_byte, operand1, operand2;
  logic        fetch_valid, fetch_ready, busy, issue, dst_dir, ptr_sel, illegal, done, win_on = 1'b0;
  aludec_op_e  op;
  aludec_src_e src;
  logic [2:0]  reg_sel, mcyc;
  logic [1:0]  len;
  int          bad_count = 0, checks_done = 0, win, win_exp;
  aludec_exp_s notes[$];
  aludec_exp_s m;
  aludec_top dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .fetch_byte_i(fetch_byte),
    .fetch_valid_i(fetch_valid), .fetch_ready_o(fetch_ready), .busy_o(busy), .issue_o(issue),
    .op_o(op), .src_o(src), .dst_dir_o(dst_dir), .reg_sel_o(reg_sel), .ptr_sel_o(ptr_sel),
    .operand1_o(operand1), .operand2_o(operand2), .len_o(len), .mcyc_o(mcyc), .illegal_o(illegal));
  aludec_fetch_model fetch_u (.clk_i(sys_clk), .rst_n_i(reset_n), .ready_i(fetch_ready),
    .stall_i(stall), .byte_o(fetch_byte), .valid_o(fetch_valid), .done_o(done));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic aludec_exp_s expect_of(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
    aludec_exp_s e;
    logic [3:0]  l;
    logic        lgc;
    l = o[3:0];
    lgc = o[7:4] inside {OPH_ANL, OPH_ORL, OPH_XRL};
    e.opc = o;
    e.ill = 1'b0;
    e.dst = 1'b0;
    e.len = LEN_ONE;
    e.mc = MCYC_ONE;
    e.src = SRC_NONE;
    case (o[7:4])
      OPH_ADD:  e.op = ALU_ADD;
      OPH_ADDC: e.op = ALU_ADDC;
      OPH_SUBB: e.op = ALU_SUBB;
      OPH_ANL:  e.op = ALU_AND;
      OPH_ORL:  e.op = ALU_OR;
      OPH_XRL:  e.op = ALU_XOR;
      default:  e.op = ALU_NONE;
    endcase
    if (o inside {OPC_RL, OPC_RLC, OPC_RR, OPC_RRC}) begin
      e.op = o[4] ? (o[5] ? ALU_RLC : ALU_RRC) : (o[5] ? ALU_RL : ALU_RR);
      e.src = SRC_ACC;
    end else if (e.op == ALU_NONE) e.ill = 1'b1;
    else if (l[3]) e.src = SRC_REG;
    else if (l[3:1] == 3'h3) e.src = SRC_IND;
    else if (l == LO_DIR || l == LO_IMM) begin
      e.src = (l == LO_DIR) ? SRC_DIR : SRC_IMM;
      e.len = LEN_TWO;
    end else if (lgc && l == LO_DIR_A) begin
      e.src = SRC_ACC;
      e.dst = 1'b1;
      e.len = LEN_TWO;
    end else if (lgc && l == LO_DIR_IMM) begin
      e.src = SRC_IMM;
      e.dst = 1'b1;
      e.len = LEN_THREE;
      e.mc = MCYC_TWO;
    end else e.ill = 1'b1;
    if (e.ill) e.op = ALU_NONE;
    e.o1 = (e.len != LEN_ONE) ? b1 : 8'h00;
    e.o2 = (e.len == LEN_THREE) ? b2 : 8'h00;
    return e;
  endfunction : expect_of
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Results are judged at the falling edge, when all registered outputs have settled
  always @(negedge sys_clk) begin
    if (win_on && busy !== 1'b1) begin
      check("exec_window", 8'(win), 8'(win_exp));
      win_on = 1'b0;
    end else if (win_on) win++;
    if (issue === 1'b1 && notes.size() > 0) begin
      m = notes.pop_front();
      check("illegal", 8'(illegal), 8'(m.ill));
      check("op", 8'(op), 8'(m.op));
      check("len", 8'(len), 8'(m.len));
      check("mcyc", 8'(mcyc), 8'(m.mc));
      check("dst_dir", 8'(dst_dir), 8'(m.dst));
      check("operand1", operand1, m.o1);
      check("operand2", operand2, m.o2);
      check("ready_exec", 8'(fetch_ready), 8'h00);
      if (m.src != SRC_NONE) check("src", 8'(src), 8'(m.src));
      if (m.src == SRC_REG) check("reg_sel", 8'(reg_sel), 8'(m.opc[2:0]));
      if (m.src == SRC_IND) check("ptr_sel", 8'(ptr_sel), 8'(m.opc[0]));
      win = 1;
      win_exp = CLK_PER_MCYC * int'(m.mc);
      win_on = 1'b1;
    end else if (notes.size() > 0 && notes[0].ill && done && busy === 1'b0) begin
      m = notes.pop_front();
      check("illegal", 8'(illegal), 8'h01);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end
  initial begin
    logic [31:0] seed;
    aludec_exp_s e;
    seed = 32'h6d34;
    repeat (20) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    @(negedge sys_clk);
    check("ready_rst", 8'(fetch_ready), 8'h01);
    check("busy_rst", 8'(busy), 8'h00);
    for (int i = 0; i < 256; i++) begin
      seed = xorshift(seed);
      e = expect_of(8'(i), seed[7:0], seed[15:8]);
      stall = seed[16];
      notes.push_back(e);
      fetch_u.load(e.opc, seed[7:0], seed[15:8], int'(e.len));
      do begin
        @(posedge sys_clk);
        #2;
      end while (!(notes.size() == 0 && done && busy === 1'b0 && !win_on));
    end
    summarize();
  end
endmodule : tb
